// [pio_card_model.sv]
`timescale 1ns/100ps
module pio_card_model
  import pio_host_pkg::*;
(
  input wire logic        core_clk,
  input wire logic [2:0]  pio_mode,
  input wire logic [7:0]  wait_cyc,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic        low_byte_card_enable_n,
  input wire logic        high_byte_card_enable_n,
  input wire logic [2:0]  host_addr,
  input wire logic [15:0] host_bus_data_out,
  output logic [15:0]     host_bus_data_in,
  output logic            iordy,
  output logic            iocs16_n
);
  // Released data shows the inverse of the last word, never a held value.
  logic [15:0] mem [8];
  logic [15:0] last = 16'h5a5a;
  logic [7:0]  wcnt = 8'h00;
  logic        tgl  = 1'b0;
  logic        stb;
  logic        word;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign stb  = !(io_read_strobe_n && io_write_strobe_n);
  assign word = !low_byte_card_enable_n && !high_byte_card_enable_n;
  // Only PIO cycles are issued, so the shorter memory-card cap never binds.
  assign iordy = !(stb && pio_mode <= WAIT_LAST_MODE
    && wcnt < wait_cyc && wcnt < 8'h7d);
  assign iocs16_n = (pio_mode <= CS16_LAST_MODE) ? !word : tgl;
  assign host_bus_data_in =
    (!io_read_strobe_n && iordy) ? mem[host_addr] : ~last;
  always @(posedge core_clk)
  begin
    tgl <= !tgl;
    wcnt <= stb ? wcnt + 8'h01 : 8'h00;
    if (!io_read_strobe_n && iordy)
      last <= mem[host_addr];
    if (!io_write_strobe_n && word)
      mem[host_addr] <= host_bus_data_out;
    else if (!io_write_strobe_n)
      mem[host_addr][7:0] <= host_bus_data_out[7:0];
  end
endmodule // pio_card_model

// [pio_host_ctrl.sv]
`timescale 1ns/100ps
module pio_host_ctrl
  import pio_host_pkg::*;
#(
  parameter int SETUP_NS = 70,
  parameter int HOLD_NS  = 20
)(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  pio_mode,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire pio_req_t    req,
  output logic             rsp_valid,
  output pio_rsp_t         rsp,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic             attribute_space_select_n,
  output logic             low_byte_card_enable_n,
  output logic             high_byte_card_enable_n,
  output logic [2:0]       host_addr,
  input  wire logic [15:0] host_bus_data_in,
  output logic [15:0]      host_bus_data_out,
  output logic             host_bus_data_oe,
  input  wire logic        iordy,
  input  wire logic        iocs16_n
);

  // ****************************************************************
  // Fixed and mode dependent counts
  // ****************************************************************
  localparam logic [CNT_W-1:0] SETUP_CYC = ns_to_cyc(SETUP_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC  = ns_to_cyc(HOLD_NS);

  pio_state_t       state_reg,   state_next;
  pio_req_t         req_reg,     req_next;
  logic [CNT_W-1:0] phase_reg,   phase_next;
  logic [CNT_W-1:0] total_reg,   total_next;
  logic [CNT_W-1:0] wait_reg,    wait_next;
  logic             waited_reg,  waited_next;
  logic             cs16_reg,    cs16_next;
  logic             tout_reg,    tout_next;
  logic [15:0]      rdata_reg,   rdata_next;
  logic             rsp_v_reg,   rsp_v_next;
  logic             first_reg,   first_next;

  logic [2:0]       mode_eff;
  logic [CNT_W-1:0] act_cyc;
  logic [CNT_W-1:0] rec_cyc;
  logic [CNT_W-1:0] cyc_cyc;
  logic             wait_enabled;
  logic             cs16_valid;
  logic             ready_s;

  always_comb
  begin
    mode_eff = (pio_mode > MODE_MAX) ? MODE_MAX : pio_mode;
    act_cyc  = ns_to_cyc(ACTIVE_NS[mode_eff]);
    if (!req_reg.word)
    begin
      act_cyc = ns_to_cyc(ACT8_NS[mode_eff]);
    end
    rec_cyc      = ns_to_cyc(RECOV_NS[mode_eff]);
    cyc_cyc      = ns_to_cyc(CYCLE_NS[mode_eff]);
    wait_enabled = (mode_eff <= WAIT_LAST_MODE);
    cs16_valid   = (mode_eff <= CS16_LAST_MODE);
  end

  ready_sync #(
    .RESET_VAL (1'b1)
  ) u_ready_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (iordy),
    .sync_out (ready_s)
  );

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_comb
  begin
    state_next  = state_reg;
    req_next    = req_reg;
    phase_next  = phase_reg + 1'b1;
    total_next  = (total_reg == '1) ? total_reg : total_reg + 1'b1;
    wait_next   = wait_reg;
    waited_next = waited_reg;
    cs16_next   = cs16_reg;
    tout_next   = tout_reg;
    rdata_next  = rdata_reg;
    rsp_v_next  = 1'b0;
    first_next  = first_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          req_next    = req;
          state_next  = ST_SETUP;
          phase_next  = '0;
          waited_next = 1'b0;
          cs16_next   = 1'b0;
          tout_next   = 1'b0;
        end
      end
      ST_SETUP:
      begin
        if (!iocs16_n && cs16_valid)
        begin
          cs16_next = 1'b1;
        end
        // A new strobe may not open before the last cycle's minimum ends.
        if (phase_reg + 1'b1 >= SETUP_CYC &&
            (first_reg || total_reg + 1'b1 >= cyc_cyc))
        begin
          state_next = ST_ACTIVE;
          phase_next = '0;
          total_next = '0;
          wait_next  = '0;
          first_next = 1'b0;
        end
      end
      ST_ACTIVE:
      begin
        // Synchroniser delay is charged so ready is sampled no sooner.
        if (wait_enabled && phase_reg + 1'b1 == SAMPLE_CYC + SYNC_LAT
            && !ready_s)
        begin
          state_next  = ST_WAIT;
          waited_next = 1'b1;
        end
        else if (phase_reg + 1'b1 >= act_cyc &&
                 phase_reg + 1'b1 > SAMPLE_CYC + SYNC_LAT)
        begin
          state_next = ST_HOLD;
          phase_next = '0;
          rdata_next = host_bus_data_in;
        end
      end
      ST_WAIT:
      begin
        wait_next = wait_reg + 1'b1;
        // A short wait must not cut the strobe below its minimum width.
        if (ready_s && phase_reg + 1'b1 >= act_cyc)
        begin
          state_next = ST_HOLD;
          phase_next = '0;
          rdata_next = host_bus_data_in;
        end
        else if (!ready_s && wait_reg >= WAIT_MAX_CYC + SYNC_LAT)
        begin
          // A card that overruns its wait limit is cut loose and flagged.
          state_next = ST_HOLD;
          phase_next = '0;
          tout_next  = 1'b1;
          rdata_next = host_bus_data_in;
        end
      end
      ST_HOLD:
      begin
        if (phase_reg + 1'b1 >= HOLD_CYC)
        begin
          state_next = ST_RECOV;
          phase_next = '0;
          rsp_v_next = 1'b1;
        end
      end
      ST_RECOV:
      begin
        if (phase_reg + 1'b1 >= rec_cyc)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= ST_IDLE;
      req_reg    <= '0;
      phase_reg  <= '0;
      total_reg  <= '0;
      wait_reg   <= '0;
      waited_reg <= 1'b0;
      cs16_reg   <= 1'b0;
      tout_reg   <= 1'b0;
      rdata_reg  <= 16'h0000;
      rsp_v_reg  <= 1'b0;
      first_reg  <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      req_reg    <= req_next;
      phase_reg  <= phase_next;
      total_reg  <= total_next;
      wait_reg   <= wait_next;
      waited_reg <= waited_next;
      cs16_reg   <= cs16_next;
      tout_reg   <= tout_next;
      rdata_reg  <= rdata_next;
      rsp_v_reg  <= rsp_v_next;
      first_reg  <= first_next;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  logic strobe_on;
  logic in_cycle;

  assign strobe_on = (state_reg == ST_ACTIVE) || (state_reg == ST_WAIT);
  assign in_cycle  = (state_reg != ST_IDLE) && (state_reg != ST_RECOV);

  assign req_ready                = (state_reg == ST_IDLE);
  assign io_read_strobe_n         = !(strobe_on && !req_reg.write);
  assign io_write_strobe_n        = !(strobe_on && req_reg.write);
  assign attribute_space_select_n = !(in_cycle && req_reg.attr);
  assign low_byte_card_enable_n   = !(in_cycle && req_reg.cs_low);
  assign high_byte_card_enable_n  = !(in_cycle && req_reg.cs_high);
  assign host_addr                = req_reg.addr;
  assign host_bus_data_out        = req_reg.word ? req_reg.wdata
                                    : {8'h00, req_reg.wdata[7:0]};
  assign host_bus_data_oe         = in_cycle && req_reg.write;
  assign rsp_valid                = rsp_v_reg;
  assign rsp.rdata                = req_reg.word ? rdata_reg
                                    : {8'h00, rdata_reg[7:0]};
  assign rsp.timeout              = tout_reg;
  assign rsp.cs16_seen            = cs16_reg;

endmodule // pio_host_ctrl

// [pio_host_pkg.sv]
// Function
// - Host keeps strobe-to-strobe cycle at least the mode's minimum cycle time; code skips this check for the first strobe after reset (first_reg).
// - Host holds strobe active for the mode's minimum, 290 ns for 8-bit modes 0-2.
// - Host keeps both strobes inactive for the mode's minimum recovery time.
// - Cycle is active plus inactive; host stretches either to reach minimum cycle; code stretches only the inactive time, in ST_SETUP.
// - Host samples ready 35 ns after strobe; if low, holds strobe until high; code cuts it off after WAIT_MAX_NS plus SYNC_LAT and flags timeout.
// - No ready waits in modes 5 and 6; host may ignore ready there.
// - 16-bit select is meaningful only in modes 0 to 2; ignored otherwise.
// - Device address is the two card enables plus the three host address lines.
// - Word accesses use all sixteen data lines, byte accesses the low eight.
package pio_host_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NUM_MODES     = 7;
  localparam int SYNC_LAT      = 2;
  localparam int CNT_W         = 8;

  localparam int CYCLE_NS [NUM_MODES] = '{600, 383, 240, 180, 120, 100, 80};
  localparam int ACTIVE_NS[NUM_MODES] = '{165, 125, 100, 80, 70, 65, 55};
  localparam int ACT8_NS  [NUM_MODES] = '{290, 290, 290, 80, 70, 65, 55};
  localparam int RECOV_NS [NUM_MODES] = '{0, 0, 0, 70, 25, 25, 20};
  localparam int READY_SAMPLE_NS = 35;
  localparam int WAIT_MAX_NS     = 1250;

  localparam logic [2:0] WAIT_LAST_MODE  = 3'h4;
  localparam logic [2:0] CS16_LAST_MODE  = 3'h2;
  localparam logic [2:0] MODE_MAX        = 3'h6;

  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

  localparam logic [CNT_W-1:0] SAMPLE_CYC = ns_to_cyc(READY_SAMPLE_NS);
  localparam logic [CNT_W-1:0] WAIT_MAX_CYC =
    CNT_W'(WAIT_MAX_NS / CLK_PERIOD_NS);

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        write;
    logic        word;
    logic        attr;
    logic        cs_low;
    logic        cs_high;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } pio_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        timeout;
    logic        cs16_seen;
  } pio_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_ACTIVE = 3'b011,
    ST_WAIT   = 3'b010,
    ST_HOLD   = 3'b110,
    ST_RECOV  = 3'b111
  } pio_state_t;

endpackage

// [pio_host_props.sv]
`timescale 1ns/100ps
module pio_host_props
  import pio_host_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] pio_mode,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic       low_byte_card_enable_n,
  input wire logic       high_byte_card_enable_n,
  input wire logic [2:0] host_addr,
  input wire logic       host_bus_data_oe,
  input wire logic       iordy
);
  // The cycle and recovery counters saturate so the first strobe after reset never fails.
  logic       idle;
  logic [7:0] act;
  logic [7:0] cyc;
  logic [7:0] rec;
  assign idle = io_read_strobe_n & io_write_strobe_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act <= 8'h00;
      cyc <= 8'hff;
      rec <= 8'hff;
    end
    else
    begin
      act <= idle ? 8'h00 : act + 8'h01;
      cyc <= $fell(idle) ? 8'h01 : cyc + 8'(cyc != 8'hff);
      rec <= !idle ? 8'h00 : rec + 8'(rec != 8'hff);
    end
  end
  a_one_strobe: assert property (
    io_read_strobe_n | io_write_strobe_n) else $error("two strobes");
  a_active_min: assert property (
    $rose(idle) |-> act * 10 >= ACTIVE_NS[pio_mode]) else $error("short");
  a_cycle_min: assert property (
    $fell(idle) |-> cyc * 10 >= CYCLE_NS[pio_mode]) else $error("cycle");
  a_recov_min: assert property (
    $fell(idle) |-> rec * 10 >= RECOV_NS[pio_mode]) else $error("recov");
  a_ready_wait: assert property (
    $rose(idle) && pio_mode <= WAIT_LAST_MODE |-> $past(iordy, 2)
    || $past(iordy, 3) || $past(iordy, 4)) else $error("no wait");
  a_fast_nowait: assert property (
    $fell(idle) && pio_mode > WAIT_LAST_MODE |-> ##[1:30] idle)
    else $error("fast mode waited");
  a_addr_stable: assert property (
    !idle && !$past(idle) |-> $stable(host_addr)
    && $stable(low_byte_card_enable_n)) else $error("addr moved");
  a_sel_on: assert property (
    !idle |-> !(low_byte_card_enable_n & high_byte_card_enable_n))
    else $error("no enable");
  a_data_dir: assert property (
    !idle |-> host_bus_data_oe == !io_write_strobe_n) else $error("dir");
  a_busy_hold: assert property (
    !idle |-> !req_ready ##1 !req_ready) else $error("ready");
  a_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid) else $error("rsp pulse");
  c_waited: cover property ($rose(iordy) && !idle);
  c_fast: cover property (rsp_valid && pio_mode == MODE_MAX);
  c_write: cover property ($fell(io_write_strobe_n));
endmodule // pio_host_props

// [ready_sync.sv]
`timescale 1ns/100ps
module ready_sync
  import pio_host_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
)(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage1_next;
  logic stage2_next;

  always_comb
  begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  // Only the second stage is visible to the rest of the design.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;

endmodule // ready_sync

// [tb.sv]
`timescale 1ns/100ps
module tb
  import pio_host_pkg::*;
();
  typedef struct packed {
    logic [2:0]  mode;
    logic        wr;
    logic        word;
    logic [2:0]  addr;
    logic [15:0] data;
    logic [7:0]  wt;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{3'h0, 1'b1, 1'b1, 3'h1, 16'h1234, 8'h00},
    '{3'h0, 1'b0, 1'b1, 3'h1, 16'h1234, 8'h14},
    '{3'h1, 1'b0, 1'b1, 3'h1, 16'h1234, 8'h00},
    '{3'h2, 1'b1, 1'b0, 3'h2, 16'h77a5, 8'h00},
    '{3'h2, 1'b0, 1'b0, 3'h2, 16'h77a5, 8'h05},
    '{3'h3, 1'b1, 1'b1, 3'h3, 16'hbeef, 8'h0a},
    '{3'h4, 1'b0, 1'b1, 3'h3, 16'hbeef, 8'h64},
    '{3'h5, 1'b1, 1'b1, 3'h4, 16'hc001, 8'h1e},
    '{3'h6, 1'b0, 1'b1, 3'h4, 16'hc001, 8'h1e}};
  logic core_clk, rst_n, req_valid, req_ready, rsp_valid;
  logic rd_n, wr_n, lo_n, hi_n, oe, iordy, iocs16_n, attr_n;
  logic [2:0]  pio_mode, addr;
  logic [7:0]  wait_cyc;
  logic [15:0] din, dout;
  pio_req_t    req;
  pio_rsp_t    rsp;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  pio_host_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .pio_mode(pio_mode), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
    .attribute_space_select_n(attr_n), .low_byte_card_enable_n(lo_n),
    .high_byte_card_enable_n(hi_n), .host_addr(addr),
    .host_bus_data_in(din), .host_bus_data_out(dout),
    .host_bus_data_oe(oe), .iordy(iordy), .iocs16_n(iocs16_n));
  pio_card_model card_u (.core_clk(core_clk), .pio_mode(pio_mode),
    .wait_cyc(wait_cyc), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
    .low_byte_card_enable_n(lo_n), .high_byte_card_enable_n(hi_n),
    .host_addr(addr), .host_bus_data_out(dout), .host_bus_data_in(din),
    .iordy(iordy), .iocs16_n(iocs16_n));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input row_t r);
    int n = 0;
    int act = 0;
    logic [15:0] wd = 16'h0;
    logic [2:0] ad = 3'h0;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    pio_mode = r.mode;
    wait_cyc = r.wt;
    req = '{r.wr, r.word, 1'b0, 1'b1, r.word, r.addr, r.data};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      if (rd_n === 1'b0 || wr_n === 1'b0)
      begin
        act++;
        ad = addr;
        wd = dout;
      end
      @(negedge core_clk);
      n++;
    end
    chk(16'(n < 400), 16'h1);
    chk(r.wr ? wd : rsp.rdata,
      r.word ? r.data : {8'h00, r.data[7:0]});
    chk({13'h0, ad}, {13'h0, r.addr});
    chk(16'(act * 10 >= (r.word ? ACTIVE_NS[r.mode] : ACT8_NS[r.mode])),
      16'h1);
    chk({15'h0, rsp.cs16_seen},
      {15'h0, r.word && r.mode <= CS16_LAST_MODE});
    chk({15'h0, rsp.timeout}, 16'h0);
  endtask
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    pio_mode = 3'h0;
    wait_cyc = 8'h00;
    req = '0;
    // Counting posedges avoids a false negedge at time zero.
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    foreach (ROWS[i])
    begin
      run(ROWS[i]);
      $display("row %0d done", i);
    end
    // A pause first, so the slow mode's cycle minimum is met again.
    repeat (60) @(negedge core_clk);
    pio_mode = 3'h0;
    req = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 16'h5555};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    repeat (10) @(negedge core_clk);
    chk({15'h0, wr_n}, 16'h0);
    chk({15'h0, attr_n}, 16'h0);
    rst_n = 1'b0;
    #1;
    chk({10'h0, attr_n, rd_n, wr_n, oe, req_ready, rsp_valid},
      16'h3a);
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    run(ROWS[0]);
    run(ROWS[1]);
    $display("reset test done");
    summarize();
  end
endmodule // tb
bind pio_host_ctrl pio_host_props chk_u (.*);
